// [rtl/iexp_map.vh]
// Offsets, field positions and counts of the interrupt expansion block
`ifndef IEXP_MAP_VH
`define IEXP_MAP_VH

// Request inputs and grouping
`define IEXP_NUM_SRC      96
`define IEXP_USED_SRC     45
`define IEXP_GRP_SIZE     8
`define IEXP_NUM_GRP      12
`define IEXP_GRP_LINE13   4'hC
`define IEXP_SRC_TIMER0   0
`define IEXP_SRC_EXT_ONE  1
`define IEXP_SRC_EXT_TWO  2

// Vector fetch plus context save, in core clocks
`define IEXP_FETCH_CYC    4'h8
`define IEXP_FETCH_LAST   4'h7

// Timestamp counters
`define IEXP_TS_W         16
`define IEXP_TS_ZERO      16'h0000
`define IEXP_TS_ONE       16'h0001

// Register byte offsets
`define IEXP_OFF_CTRL     12'h000
`define IEXP_OFF_STAT     12'h004
`define IEXP_OFF_MASK     12'h008
`define IEXP_OFF_XCTL     12'h010
`define IEXP_OFF_XCTL_END 12'h020
`define IEXP_OFF_XCNT     12'h020
`define IEXP_OFF_XCNT_END 12'h02C
`define IEXP_OFF_EN       12'h040
`define IEXP_OFF_EN_END   12'h070
`define IEXP_OFF_PEND     12'h080
`define IEXP_OFF_PEND_END 12'h0B0
`define IEXP_OFF_VEC      12'h200
`define IEXP_OFF_VEC_END  12'h380

// Field positions
`define IEXP_CTRL_T1SEL   0
`define IEXP_XCTL_EN      0
`define IEXP_XCTL_POS     1
`define IEXP_ST_W         5
`define IEXP_ST_WAKE      4

// Low-power mode codes
`define IEXP_LPM_RUN      2'h0
`define IEXP_LPM_IDLE     2'h1
`define IEXP_LPM_STBY     2'h2
`define IEXP_LPM_HALT     2'h3

// Bus answers and reset values
`define IEXP_RESP_OKAY    2'h0
`define IEXP_RESP_SLVERR  2'h2
`define IEXP_ZERO32       32'h0000_0000

`endif

// [rtl/iexp_top.v]
// Interrupt expansion, external interrupts and wake-up logic
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "iexp_map.vh"

// Contract
// - Accept 96 request inputs, 45 used.
// - Groups of eight feed twelve core lines.
// - Each input owns writable vector RAM entry.
// - Vector fetch plus save takes 8 cycles.
// - Per-input enable blocks disabled requests.
// - Priority from fixed order and software enables.
// - Three maskable external interrupt inputs.
// - Line thirteen shares pin with non-maskable.
// - Each external: edge polarity select, enable.
// - 16-bit counters cleared on valid edge.
// - Timer two drives line fourteen directly.
// - Timer one optionally drives line thirteen.
// - Timer zero is an expansion request input.
// - Idle: enabled running-peripheral request wakes core.
// - Standby: external event wakes, resumes next cycle.
// - Halt: only non-maskable edge wakes.
module iexp_top
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [92:0] periph_req,
  input  wire [95:0] periph_clk_on,
  input  wire        core_timer_zero_irq,
  input  wire        core_timer_one_irq,
  input  wire        core_timer_two_irq,
  input  wire        ext_irq_one_pin,
  input  wire        ext_irq_two_pin,
  input  wire        combined_ext_irq_pin,
  input  wire [1:0]  lpm_mode,
  input  wire        core_ack,
  input  wire [3:0]  core_ack_grp,
  output wire [11:0] core_irq_lines,
  output wire        core_irq_line_thirteen,
  output wire        core_irq_line_fourteen,
  output wire        core_nmi,
  output wire        vec_busy,
  output wire        vec_valid,
  output wire [31:0] vec_data,
  output wire [6:0]  vec_index,
  output wire        wake,
  output wire        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Fetch sequencer states, one-hot
  localparam [2:0] ST_IDLE  = 3'b001;
  localparam [2:0] ST_FETCH = 3'b010;
  localparam [2:0] ST_DONE  = 3'b100;

  reg  [31:0] vec_ram [0:95];   // One vector per request input
  reg  [95:0] pend_q;           // Latched requests
  reg  [95:0] en_q;             // Per-input enables
  reg         t1sel_q;          // Timer one owns line thirteen
  reg  [4:0]  stat_q;           // Sticky event status
  reg  [4:0]  mask_q;           // Interrupt mask
  reg  [3:0]  xen_q;            // External enables
  reg  [3:0]  xpos_q;           // External polarity, 1 is rising
  reg  [3:0]  xprev_q;          // Previous pin levels
  reg  [47:0] xcnt_q;           // Three timestamp counters
  reg         line13_q;         // Registered line thirteen
  reg         nmi_q;            // Registered non-maskable pulse
  reg         wake_q;           // Registered wake pulse
  reg  [2:0]  state_q;          // Fetch state
  reg  [3:0]  fcnt_q;           // Fetch cycle count
  reg  [6:0]  fidx_q;           // Entry being fetched
  reg         vvalid_q;         // Vector ready pulse
  reg  [31:0] vdata_q;          // Fetched vector
  reg         aw_hold_q;        // Write address held
  reg  [11:0] aw_addr_q;
  reg         w_hold_q;         // Write data held
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg         bvalid_q;
  reg  [1:0]  bresp_q;
  reg         rvalid_q;
  reg  [31:0] rdata_q;
  reg  [1:0]  rresp_q;

  wire [95:0] req_all;          // All request sources
  wire [3:0]  xpin;             // Pin per external channel
  wire [3:0]  xedge;            // Valid edge per channel
  wire [11:0] grp_any;          // Group has enabled pending
  wire [35:0] grp_sel;          // Lowest pending per group
  wire [31:0] bmask;            // Byte-lane mask of a write
  wire        do_wr;            // Address and data both held
  wire        take_ar;          // Read address accepted
  wire        ack_ok;           // Acknowledge hits a live group
  wire [6:0]  ack_idx;          // Entry chosen by acknowledge
  wire        wake_d;
  wire [4:0]  stat_ev;
  wire [11:0] wd;               // Write offsets from each base
  wire [11:0] wd_x;
  wire [11:0] wd_e;
  wire [11:0] wd_v;
  wire [11:0] rd_x;
  wire [11:0] rd_c;
  wire [11:0] rd_e;
  wire [11:0] rd_p;
  wire [11:0] rd_v;
  reg  [31:0] rd_mux;           // Read data for a register address
  reg         rd_hit;           // Read address mapped
  reg         wr_hit;           // Write address mapped
  reg  [95:0] pend_clr;         // Entry cleared by acknowledge
  reg  [2:0]  state_d;

  // Lowest set bit of an 8-bit group
  function [2:0] iexp_low;
    input [7:0] v;
    integer k;
    begin
      iexp_low = 3'h0;
      for (k = 7; k >= 0; k = k - 1)
        if (v[k])
          iexp_low = k[2:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request sources and group combining

  // Timer zero and the two external events join the peripheral inputs
  assign req_all = {periph_req, xedge[1], xedge[0],
                    core_timer_zero_irq};

  // One priority encoder and line per group of eight
  genvar g;
  generate
    for (g = 0; g < `IEXP_NUM_GRP; g = g + 1)
    begin : grp
      wire [7:0] gv;
      // Enabled pending requests of this group only
      assign gv = pend_q[g*`IEXP_GRP_SIZE +: `IEXP_GRP_SIZE] &
                  en_q[g*`IEXP_GRP_SIZE +: `IEXP_GRP_SIZE];
      assign grp_any[g] = |gv;
      assign grp_sel[g*3 +: 3] = iexp_low(gv);
    end
  endgenerate

  assign core_irq_lines = grp_any;

  // Acknowledge of an empty or out-of-range group is ignored
  assign ack_ok  = core_ack && (core_ack_grp < `IEXP_GRP_LINE13) &&
                   grp_any[core_ack_grp];
  assign ack_idx = {core_ack_grp[3:0], grp_sel[core_ack_grp*3 +: 3]};

  // One-hot clear of the acknowledged entry
  always @*
  begin
    pend_clr = 96'h0;
    if (ack_ok && state_q == ST_IDLE)
      pend_clr[ack_idx] = 1'b1;
  end

  // Pending flags; a new request beats a same-cycle clear
  always @(posedge aclk)
  begin
    if (!aresetn)
      pend_q <= 96'h0;
    else
      pend_q <= (pend_q & ~pend_clr) | req_all;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector fetch sequencer

  // Next state
  always @*
  begin
    case (state_q)
      ST_IDLE:
        state_d = ack_ok ? ST_FETCH : ST_IDLE;
      ST_FETCH:
        state_d = (fcnt_q == `IEXP_FETCH_LAST) ? ST_DONE : ST_FETCH;
      ST_DONE:
        state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  // Counts eight cycles, then hands the vector out for one cycle
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q  <= ST_IDLE;
      fcnt_q   <= 4'h0;
      fidx_q   <= 7'h00;
      vvalid_q <= 1'b0;
      vdata_q  <= `IEXP_ZERO32;
    end
    else
    begin
      state_q  <= state_d;
      vvalid_q <= 1'b0;
      if (state_q == ST_IDLE && ack_ok)
      begin
        fidx_q <= ack_idx;
        fcnt_q <= 4'h0;
      end
      else if (state_q == ST_FETCH)
      begin
        fcnt_q <= fcnt_q + 4'h1;
        // Entry read late so a rewrite during fetch still counts
        if (fcnt_q == `IEXP_FETCH_LAST)
        begin
          vvalid_q <= 1'b1;
          vdata_q  <= vec_ram[fidx_q];
        end
      end
    end
  end

  assign vec_busy  = (state_q != ST_IDLE);
  assign vec_valid = vvalid_q;
  assign vec_data  = vdata_q;
  assign vec_index = fidx_q;

  ////////////////////////////////////////////////////////////////////////////
  // External interrupts and timestamps

  // Line thirteen and the non-maskable one see the same pin
  assign xpin = {combined_ext_irq_pin, combined_ext_irq_pin,
                 ext_irq_two_pin, ext_irq_one_pin};

  genvar c;
  generate
    for (c = 0; c < 4; c = c + 1)
    begin : xch
      // Edge of the chosen polarity, only while enabled
      assign xedge[c] = xen_q[c] & (xpos_q[c] ?
                        (xpin[c] & ~xprev_q[c]) :
                        (~xpin[c] & xprev_q[c]));
    end
    for (c = 0; c < 3; c = c + 1)
    begin : xts
      // Free-running stamp, zeroed by its own valid edge
      always @(posedge aclk)
      begin
        if (!aresetn)
          xcnt_q[c*16 +: 16] <= `IEXP_TS_ZERO;
        else if (xedge[c])
          xcnt_q[c*16 +: 16] <= `IEXP_TS_ZERO;
        else
          xcnt_q[c*16 +: 16] <= xcnt_q[c*16 +: 16] +
                                `IEXP_TS_ONE;
      end
    end
  endgenerate

  // Pin history and core-side strobes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      xprev_q  <= 4'h0;
      line13_q <= 1'b0;
      nmi_q    <= 1'b0;
    end
    else
    begin
      xprev_q  <= xpin;
      line13_q <= t1sel_q ? core_timer_one_irq : xedge[2];
      nmi_q    <= xedge[3];
    end
  end

  assign core_irq_line_thirteen = line13_q;
  assign core_irq_line_fourteen = core_timer_two_irq;
  assign core_nmi               = nmi_q;

  ////////////////////////////////////////////////////////////////////////////
  // Low-power wake-up

  // Idle needs a clocked peripheral; halt listens to one pin only
  assign wake_d =
    ((lpm_mode == `IEXP_LPM_IDLE) &&
     |(pend_q & en_q & periph_clk_on)) ||
    ((lpm_mode == `IEXP_LPM_STBY) && |xedge) ||
    ((lpm_mode == `IEXP_LPM_HALT) && xedge[3]);

  always @(posedge aclk)
  begin
    if (!aresetn)
      wake_q <= 1'b0;
    else
      wake_q <= wake_d;
  end

  assign wake = wake_q;

  ////////////////////////////////////////////////////////////////////////////
  // Event status and interrupt output

  assign stat_ev = {wake_d, xedge};
  assign bmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                    {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // Write-one clears, but a fresh event wins
  always @(posedge aclk)
  begin
    if (!aresetn)
      stat_q <= 5'h00;
    else if (do_wr && aw_addr_q == `IEXP_OFF_STAT)
      stat_q <= (stat_q & ~(w_data_q[4:0] & bmask[4:0])) | stat_ev;
    else
      stat_q <= stat_q | stat_ev;
  end

  assign irq = |(stat_q & mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: write channel

  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready  = ~w_hold_q & ~bvalid_q;
  assign do_wr         = aw_hold_q & w_hold_q & ~bvalid_q;
  assign wd_x = aw_addr_q - `IEXP_OFF_XCTL;
  assign wd_e = aw_addr_q - `IEXP_OFF_EN;
  assign wd_v = aw_addr_q - `IEXP_OFF_VEC;
  assign wd   = aw_addr_q;

  // Write decode
  always @*
  begin
    wr_hit = (wd == `IEXP_OFF_CTRL) || (wd == `IEXP_OFF_STAT) ||
             (wd == `IEXP_OFF_MASK) ||
             (wd >= `IEXP_OFF_XCTL && wd < `IEXP_OFF_XCTL_END) ||
             (wd >= `IEXP_OFF_EN && wd < `IEXP_OFF_EN_END) ||
             (wd >= `IEXP_OFF_VEC && wd < `IEXP_OFF_VEC_END);
  end

  // Channel capture, register update and response
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= 12'h000;
      w_hold_q  <= 1'b0;
      w_data_q  <= `IEXP_ZERO32;
      w_strb_q  <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `IEXP_RESP_OKAY;
      en_q      <= 96'h0;
      t1sel_q   <= 1'b0;
      mask_q    <= 5'h00;
      xen_q     <= 4'h0;
      xpos_q    <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        bvalid_q <= 1'b0;
      if (do_wr)
      begin
        aw_hold_q <= 1'b0;
        w_hold_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= wr_hit ? `IEXP_RESP_OKAY : `IEXP_RESP_SLVERR;
        if (wd == `IEXP_OFF_CTRL && w_strb_q[0])
          t1sel_q <= w_data_q[`IEXP_CTRL_T1SEL];
        if (wd == `IEXP_OFF_MASK && w_strb_q[0])
          mask_q <= w_data_q[4:0];
        if (wd >= `IEXP_OFF_XCTL && wd < `IEXP_OFF_XCTL_END &&
            w_strb_q[0])
        begin
          xen_q[wd_x[3:2]]  <= w_data_q[`IEXP_XCTL_EN];
          xpos_q[wd_x[3:2]] <= w_data_q[`IEXP_XCTL_POS];
        end
        // Software enables shape which request wins a line
        if (wd >= `IEXP_OFF_EN && wd < `IEXP_OFF_EN_END &&
            w_strb_q[0])
          en_q[wd_e[5:2]*8 +: 8] <= w_data_q[7:0];
      end
    end
  end

  // Vector RAM, writable at any time, byte lanes honoured
  always @(posedge aclk)
  begin
    if (do_wr && wd >= `IEXP_OFF_VEC && wd < `IEXP_OFF_VEC_END)
    begin
      if (w_strb_q[0])
        vec_ram[wd_v[8:2]][7:0] <= w_data_q[7:0];
      if (w_strb_q[1])
        vec_ram[wd_v[8:2]][15:8] <= w_data_q[15:8];
      if (w_strb_q[2])
        vec_ram[wd_v[8:2]][23:16] <= w_data_q[23:16];
      if (w_strb_q[3])
        vec_ram[wd_v[8:2]][31:24] <= w_data_q[31:24];
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: read channel

  assign s_axi_arready = ~rvalid_q;
  assign take_ar       = s_axi_arvalid & ~rvalid_q;
  assign rd_x = s_axi_araddr - `IEXP_OFF_XCTL;
  assign rd_c = s_axi_araddr - `IEXP_OFF_XCNT;
  assign rd_e = s_axi_araddr - `IEXP_OFF_EN;
  assign rd_p = s_axi_araddr - `IEXP_OFF_PEND;
  assign rd_v = s_axi_araddr - `IEXP_OFF_VEC;

  // Register read mux; unused bits read zero
  always @*
  begin
    rd_mux = `IEXP_ZERO32;
    rd_hit = 1'b1;
    if (s_axi_araddr[11:2] == `IEXP_OFF_CTRL >> 2)
      rd_mux[0] = t1sel_q;
    else if (s_axi_araddr[11:2] == `IEXP_OFF_STAT >> 2)
      rd_mux[4:0] = stat_q;
    else if (s_axi_araddr[11:2] == `IEXP_OFF_MASK >> 2)
      rd_mux[4:0] = mask_q;
    else if (s_axi_araddr >= `IEXP_OFF_XCTL &&
             s_axi_araddr < `IEXP_OFF_XCTL_END)
      rd_mux[1:0] = {xpos_q[rd_x[3:2]], xen_q[rd_x[3:2]]};
    else if (s_axi_araddr >= `IEXP_OFF_XCNT &&
             s_axi_araddr < `IEXP_OFF_XCNT_END)
      rd_mux[15:0] = xcnt_q[rd_c[3:2]*16 +: 16];
    else if (s_axi_araddr >= `IEXP_OFF_EN &&
             s_axi_araddr < `IEXP_OFF_EN_END)
      rd_mux[7:0] = en_q[rd_e[5:2]*8 +: 8];
    else if (s_axi_araddr >= `IEXP_OFF_PEND &&
             s_axi_araddr < `IEXP_OFF_PEND_END)
      rd_mux[7:0] = pend_q[rd_p[5:2]*8 +: 8];
    else if (s_axi_araddr >= `IEXP_OFF_VEC &&
             s_axi_araddr < `IEXP_OFF_VEC_END)
      rd_mux = `IEXP_ZERO32;
    else
      rd_hit = 1'b0;
  end

  // Registered answer one cycle after the address is taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= `IEXP_ZERO32;
      rresp_q  <= `IEXP_RESP_OKAY;
    end
    else if (take_ar)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? `IEXP_RESP_OKAY : `IEXP_RESP_SLVERR;
      if (s_axi_araddr >= `IEXP_OFF_VEC &&
          s_axi_araddr < `IEXP_OFF_VEC_END)
        rdata_q <= vec_ram[rd_v[8:2]];
      else
        rdata_q <= rd_mux;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata  = rdata_q;
  assign s_axi_rresp  = rresp_q;

endmodule // iexp_top

// [testbench/iexp_props.sv]
// Port assertions for the interrupt expansion block
`timescale 1ns/1ps
module iexp_props
(
  input wire        aclk,
  input wire        aresetn,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        core_timer_two_irq,
  input wire [3:0]  core_ack_grp,
  input wire        core_irq_line_fourteen,
  input wire        core_nmi,
  input wire        vec_busy,
  input wire        vec_valid,
  input wire [6:0]  vec_index
);
  ////////////////////////////////////////////////////////////////////////////
  // One clock domain
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Fetch busy phase
  sequence s_fetch_busy;
    vec_busy [*8];
  endsequence

  // Valid pulse ends fetch
  sequence s_fetch_done;
    vec_valid ##1 !vec_valid;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_fetch_eight:
    assert property ($rose(vec_busy) |-> s_fetch_busy ##1 s_fetch_done)
    else $error("vector fetch length wrong");
  a_valid_busy:
    assert property (vec_valid |-> vec_busy)
    else $error("vector valid outside fetch");
  a_index_group:
    assert property ($rose(vec_valid)
                     |-> vec_index[6:3] == $past(core_ack_grp, 9))
    else $error("vector index wrong group");
  a_line14_copy:
    assert property (core_irq_line_fourteen == core_timer_two_irq)
    else $error("line 14 not timer two");
  a_nmi_pulse:
    assert property (core_nmi |=> !core_nmi)
    else $error("nmi pulse too long");
  a_bresp_hold:
    assert property (s_axi_bvalid && !s_axi_bready
                     |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp not held");
  a_rdata_hold:
    assert property (s_axi_rvalid && !s_axi_rready
                     |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata not held");
  a_ar_refused:
    assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("ar taken while r pending");
endmodule // iexp_props

// [testbench/iexp_core_model.sv]
// Behavioural core: acks lines, collects vectors
`timescale 1ns/1ps
module iexp_core_model
(
  input wire         aclk,
  input wire         aresetn,
  input wire         svc_on,
  input wire [11:0]  core_irq_lines,
  input wire         vec_busy,
  input wire         vec_valid,
  input wire [31:0]  vec_data,
  input wire [6:0]   vec_index,
  output reg         core_ack,
  output reg [3:0]   core_ack_grp,
  output reg [31:0]  last_data,
  output reg [6:0]   last_index,
  output reg [7:0]   last_lat,
  output reg [7:0]   fetch_cnt
);
  reg     [7:0] lat_q;   // Edges since the acknowledge was taken
  reg           wait_q;  // Waiting for the vector
  integer       g;
  ////////////////////////////////////////////////////////////////////////////
  // Ack lowest line; idle group code is illegal
  always @(posedge aclk)
  begin
    core_ack     <= 1'b0;
    core_ack_grp <= 4'hF;
    if (!aresetn)
    begin
      wait_q    <= 1'b0;
      fetch_cnt <= 8'h00;
    end
    else if (wait_q)
    begin
      lat_q <= lat_q + 8'h01;
      // Latency from the taking edge
      if (vec_valid)
      begin
        wait_q     <= 1'b0;
        last_data  <= vec_data;
        last_index <= vec_index;
        last_lat   <= lat_q;
        fetch_cnt  <= fetch_cnt + 8'h01;
      end
    end
    else if (svc_on && !vec_busy && (|core_irq_lines))
    begin
      for (g = 11; g >= 0; g = g - 1)
        if (core_irq_lines[g])
          core_ack_grp <= g[3:0];
      core_ack <= 1'b1;
      wait_q   <= 1'b1;
      lat_q    <= 8'hFF;
    end
  end
endmodule // iexp_core_model

// [testbench/interrupt_expansion_and_ext_irq_test.sv]
// Self-checking bench for the interrupt expansion block
`timescale 1ns/1ps
`include "iexp_map.vh"
module interrupt_expansion_and_ext_irq_test;
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg  [11:0] awaddr, araddr;
  reg  [31:0] wdata, rd;
  reg  [1:0]  rs, lpm;
  reg  [92:0] preq;
  reg         tz, t1, t2, px1, px2, pc, svc, hw, hn;
  wire        awready, wready, bvalid, arready, rvalid, ack;
  wire        l13, l14, nmi, busy, vval, wake, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata, vdata, ldata;
  wire [11:0] lines;
  wire [6:0]  vidx, lidx;
  wire [3:0]  grp;
  wire [7:0]  llat, fcnt;
  integer     errors, num_checks;

  iexp_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .periph_req(preq),
    .periph_clk_on({96{1'b1}}), .core_timer_zero_irq(tz),
    .core_timer_one_irq(t1), .core_timer_two_irq(t2),
    .ext_irq_one_pin(px1), .ext_irq_two_pin(px2),
    .combined_ext_irq_pin(pc), .lpm_mode(lpm), .core_ack(ack),
    .core_ack_grp(grp), .core_irq_lines(lines),
    .core_irq_line_thirteen(l13), .core_irq_line_fourteen(l14),
    .core_nmi(nmi), .vec_busy(busy), .vec_valid(vval), .vec_data(vdata),
    .vec_index(vidx), .wake(wake), .irq(irq));

  iexp_core_model core (.aclk(aclk), .aresetn(aresetn), .svc_on(svc),
    .core_irq_lines(lines), .vec_busy(busy), .vec_valid(vval),
    .vec_data(vdata), .vec_index(vidx), .core_ack(ack),
    .core_ack_grp(grp), .last_data(ldata), .last_index(lidx),
    .last_lat(llat), .fetch_cnt(fcnt));

  ////////////////////////////////////////////////////////////////////////////
  // Free-running 25 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  // Compare; unknowns never match
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        errors = errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  // Verdict
  task tally_and_finish;
    begin
      if (errors == 0 && num_checks > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // Bounded wait failed
  task hang;
    begin
      errors = errors + 1;
      tally_and_finish;
    end
  endtask

  // AXI write; channels drop when taken
  task wr(input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do
      begin
        @(posedge aclk);
        n = n + 1;
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 40);
      rs = bresp;
      bready <= 1'b0;
      if (n >= 40) hang;
    end
  endtask

  // AXI read; answer taken at rvalid edge
  task rdw(input [11:0] a);
    integer n;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do
      begin
        @(posedge aclk);
        n = n + 1;
        if (arready) arvalid <= 1'b0;
      end while (!rvalid && n < 40);
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (n >= 40) hang;
    end
  endtask

  // Wait for k collected vectors
  task wfetch(input [7:0] k);
    integer n;
    begin
      n = 0;
      while (fcnt !== k && n < 60)
      begin
        @(posedge aclk);
        n = n + 1;
      end
      if (n >= 60) hang;
    end
  endtask

  // Watch wake and nmi for n cycles
  task win(input integer n);
    begin
      hw = 1'b0;
      hn = 1'b0;
      repeat (n)
      begin
        @(posedge aclk);
        hw = hw | wake;
        hn = hn | nmi;
      end
    end
  endtask

  // One-cycle timer zero request
  task tz_pulse;
    begin
      tz <= 1'b1;
      @(posedge aclk);
      tz <= 1'b0;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    errors = 0;
    num_checks = 0;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {tz, t1, t2, px1, px2, pc, svc} = 7'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    preq = {93{1'b0}};
    lpm = `IEXP_LPM_RUN;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset value and unmapped places
    rdw(`IEXP_OFF_CTRL);
    chk(rd, `IEXP_ZERO32);
    rdw(12'h0FC);
    chk(32'(rs), 32'(`IEXP_RESP_SLVERR));
    chk(rd, `IEXP_ZERO32);
    wr(12'h0F0, 32'h0000_0001);
    chk(32'(rs), 32'(`IEXP_RESP_SLVERR));
    // Vectors and enables
    wr(`IEXP_OFF_VEC, 32'h1234_5678);
    wr(`IEXP_OFF_VEC + 12'h020, 32'h0000_0A08);
    wr(`IEXP_OFF_VEC + 12'h024, 32'h0000_0A09);
    rdw(`IEXP_OFF_VEC + 12'h020);
    chk(rd, 32'h0000_0A08);
    wr(`IEXP_OFF_EN, 32'h0000_0001);
    wr(`IEXP_OFF_EN + 12'h004, 32'h0000_0003);
    // Idle wake by timer zero, serviced
    lpm <= `IEXP_LPM_IDLE;
    tz_pulse;
    win(4);
    chk(32'(hw), 32'h1);
    chk(32'(lines), 32'h1);
    lpm <= `IEXP_LPM_RUN;
    svc <= 1'b1;
    wfetch(8'h01);
    chk(32'(lidx), 32'h0);
    chk(ldata, 32'h1234_5678);
    chk(32'(llat), 32'(`IEXP_FETCH_CYC));
    // Inputs 8, 9 enabled, 10 disabled
    svc <= 1'b0;
    preq <= 93'h0E0;
    @(posedge aclk);
    preq <= {93{1'b0}};
    repeat (2) @(posedge aclk);
    chk(32'(lines), 32'h2);
    svc <= 1'b1;
    wfetch(8'h02);
    chk(32'(lidx), 32'h8);
    chk(ldata, 32'h0000_0A08);
    wfetch(8'h03);
    chk(32'(lidx), 32'h9);
    repeat (12) @(posedge aclk);
    chk(32'(lines), 32'h0);
    // Timer lines 14 and 13
    t1 <= 1'b1;
    t2 <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(32'(l14), 32'h1);
    chk(32'(l13), 32'h0);
    wr(`IEXP_OFF_CTRL, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    chk(32'(l13), 32'h1);
    t1 <= 1'b0;
    t2 <= 1'b0;
    wr(`IEXP_OFF_CTRL, 32'h0000_0000);
    // External one: edge, stamp, status
    wr(`IEXP_OFF_STAT, 32'h0000_001F);
    rdw(`IEXP_OFF_XCNT);
    chk(32'(rd > 32'd100), 32'h1);
    wr(`IEXP_OFF_XCTL, 32'h0000_0003);
    lpm <= `IEXP_LPM_STBY;
    px1 <= 1'b1;
    win(3);
    lpm <= `IEXP_LPM_RUN;
    chk(32'(hw), 32'h1);
    rdw(`IEXP_OFF_XCNT);
    chk(32'(rd < 32'd12), 32'h1);
    rdw(`IEXP_OFF_STAT);
    chk(rd, 32'h0000_0011);
    chk(32'(irq), 32'h0);
    wr(`IEXP_OFF_MASK, 32'h0000_0001);
    @(posedge aclk);
    chk(32'(irq), 32'h1);
    px1 <= 1'b0;
    repeat (3) @(posedge aclk);
    wr(`IEXP_OFF_STAT, 32'h0000_0011);
    @(posedge aclk);
    chk(32'(irq), 32'h0);
    rdw(`IEXP_OFF_STAT);
    chk(rd, `IEXP_ZERO32);
    chk(32'(lines), 32'h0);
    // Halt: only a falling edge on the shared pin wakes
    wr(`IEXP_OFF_XCTL + 12'h00C, 32'h0000_0001);
    lpm <= `IEXP_LPM_HALT;
    pc <= 1'b1;
    tz_pulse;
    win(6);
    chk(32'(hw), 32'h0);
    chk(32'(hn), 32'h0);
    pc <= 1'b0;
    win(4);
    chk(32'(hn), 32'h1);
    chk(32'(hw), 32'h1);
    lpm <= `IEXP_LPM_RUN;
    tally_and_finish;
  end
endmodule // interrupt_expansion_and_ext_irq_test

bind iexp_top iexp_props u_props (.*);
